//--- rtl/ltc_pkg.sv
// constants and types shared by the timebase and capture timer
package ltc_pkg;

  // ==========================================================
  // register indices; byte address is four times the index
  localparam logic [5:0] LTC_IDX_CSR2 = 6'h08;
  localparam logic [5:0] LTC_IDX_RELOAD = 6'h09;
  localparam logic [5:0] LTC_IDX_CNT2 = 6'h0a;
  localparam logic [5:0] LTC_IDX_CSR1 = 6'h0b;
  localparam logic [5:0] LTC_IDX_CAPTURE = 6'h0c;
  localparam logic [5:0] LTC_IDX_EVT_STAT = 6'h0d;
  localparam logic [5:0] LTC_IDX_EVT_MASK = 6'h0e;

  // ==========================================================
  // field positions of the second control/status register
  localparam int LTC_CSR2_SECOND_TIMEBASE_IRQ_ENABLE = 1;
  localparam int LTC_CSR2_SECOND_TIMEBASE_FLAG = 0;
  // field positions of the first control/status register
  localparam int LTC_CSR1_CAPTURE_IRQ_ENABLE = 7;
  localparam int LTC_CSR1_ICF = 6;
  localparam int LTC_CSR1_TB = 5;
  localparam int LTC_CSR1_FIRST_TIMEBASE_IRQ_ENABLE = 4;
  localparam int LTC_CSR1_FIRST_TIMEBASE_FLAG = 3;
  // bit positions in the event status and mask registers
  localparam int LTC_EVT_TB1 = 0;
  localparam int LTC_EVT_TB2 = 1;
  localparam int LTC_EVT_CAP = 2;

  // ==========================================================
  // reset values
  localparam logic [7:0] LTC_RST_BYTE = 8'h00;
  localparam logic [2:0] LTC_RST_EVT = 3'h0;
  localparam logic [4:0] LTC_RST_PRE = 5'h00;

  // ==========================================================
  // timing: oscillator is clk_i, counters run at one thirty-second of it
  localparam int LTC_PRESCALE = 32;
  localparam int LTC_TB_PERIOD_OSC = 8000;
  localparam logic [4:0] LTC_PRE_LAST = 5'(LTC_PRESCALE - 1);
  localparam logic [7:0] LTC_CNT1_TOP = 8'(LTC_TB_PERIOD_OSC / LTC_PRESCALE - 1);
  localparam logic [7:0] LTC_CNT2_TOP = 8'hff;

  // ==========================================================
  // per-event interrupt request lines
  typedef struct packed {
    logic tb1;
    logic tb2;
    logic cap;
  } ltc_irq_t;

  // complete state of the timer
  typedef struct packed {
    logic [4:0] pre;
    logic [7:0] cnt1;
    logic half;
    logic [7:0] cnt2;
    logic [7:0] reload;
    logic second_timebase_irq_enable;
    logic second_timebase_flag;
    logic capture_irq_enable;
    logic capture_flag;
    logic tb;
    logic first_timebase_irq_enable;
    logic first_timebase_flag;
    logic [7:0] capv;
    logic pin_q;
    logic [2:0] evt_stat;
    logic [2:0] evt_mask;
    logic ack;
    logic [7:0] dat;
    ltc_irq_t irq;
    logic irq_any;
  } ltc_state_t;

endpackage : ltc_pkg

//--- rtl/ltc_timer.sv
// timebase counters, autoreload counter and edge capture behind wishbone
//
// Register access over Wishbone was left to the implementer.
`timescale 1ns/1ps

module ltc_timer
  import ltc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic capture_input_pin_i,
  input wire logic halt_i,
  output ltc_irq_t irq_lines_o,
  output logic irq_o
);

  ltc_state_t st;
  ltc_state_t next_st;

  // ==========================================================
  // bus decode
  logic take;
  logic rd;
  logic wr;
  logic [5:0] idx;
  logic tick;
  logic ovf1;
  logic ovf2;
  logic edge_seen;
  logic cap_now;
  logic [7:0] csr1_rd;
  logic [7:0] csr2_rd;

  // one access per request; ack masks the held request on its answer cycle
  assign take = wb_cyc_i && wb_stb_i && !st.ack;
  assign rd = take && !wb_we_i;
  assign wr = take && wb_we_i && wb_sel_i[0];
  assign idx = wb_adr_i[7:2];

  // ==========================================================
  // counter events
  // halt gate
  assign tick = (st.pre == LTC_PRE_LAST) && !halt_i;
  assign ovf1 = tick && (st.cnt1 == LTC_CNT1_TOP);
  assign ovf2 = tick && (st.cnt2 == LTC_CNT2_TOP);
  // pin is synchronous, so one history flop suffices for edge detect
  assign edge_seen = capture_input_pin_i != st.pin_q;
  assign cap_now = edge_seen && !st.capture_flag;

  assign csr2_rd = {6'h00, st.second_timebase_irq_enable, st.second_timebase_flag};
  assign csr1_rd = {st.capture_irq_enable, st.capture_flag, st.tb, st.first_timebase_irq_enable, st.first_timebase_flag, 3'h0};

  // ==========================================================
  // next state
  always_comb
  begin
    next_st = st;
    next_st.pin_q = capture_input_pin_i;
    // prescaler stops with the counters in halt
    if (!halt_i)
    begin
      next_st.pre = 5'(st.pre + 5'h01);
    end
    // counter 1 runs zero to top
    if (ovf1)
    begin
      next_st.cnt1 = 8'h00;
      next_st.half = !st.half;
    end
    else if (tick)
    begin
      next_st.cnt1 = 8'(st.cnt1 + 8'h01);
    end
    if (ovf2)
    begin
      next_st.cnt2 = st.reload;
    end
    else if (tick)
    begin
      next_st.cnt2 = 8'(st.cnt2 + 8'h01);
    end

    // register writes; flags and counter 2 ignore writes
    // decode by word index
    if (wr)
    begin
      case (idx)
        LTC_IDX_CSR2:
        begin
          next_st.second_timebase_irq_enable = wb_dat_i[LTC_CSR2_SECOND_TIMEBASE_IRQ_ENABLE];
        end
        LTC_IDX_RELOAD:
        begin
          next_st.reload = wb_dat_i[7:0];
        end
        LTC_IDX_CSR1:
        begin
          next_st.capture_irq_enable = wb_dat_i[LTC_CSR1_CAPTURE_IRQ_ENABLE];
          next_st.tb = wb_dat_i[LTC_CSR1_TB];
          next_st.first_timebase_irq_enable = wb_dat_i[LTC_CSR1_FIRST_TIMEBASE_IRQ_ENABLE];
        end
        LTC_IDX_EVT_STAT:
        begin
          next_st.evt_stat = st.evt_stat & ~wb_dat_i[2:0];
        end
        LTC_IDX_EVT_MASK:
        begin
          next_st.evt_mask = wb_dat_i[2:0];
        end
        default:
        begin
          next_st.evt_mask = st.evt_mask;
        end
      endcase
    end

    // read data is captured with the answer; clear-on-read acts here too
    next_st.ack = take;
    next_st.dat = 8'h00;
    if (rd)
    begin
      case (idx)
        LTC_IDX_CSR2:
        begin
          next_st.dat = csr2_rd;
          next_st.second_timebase_flag = 1'b0;
        end
        LTC_IDX_RELOAD: next_st.dat = st.reload;
        LTC_IDX_CNT2: next_st.dat = st.cnt2;
        LTC_IDX_CSR1:
        begin
          next_st.dat = csr1_rd;
          next_st.first_timebase_flag = 1'b0;
        end
        LTC_IDX_CAPTURE:
        begin
          next_st.dat = st.capv;
          next_st.capture_flag = 1'b0;
        end
        LTC_IDX_EVT_STAT: next_st.dat = {5'h00, st.evt_stat};
        LTC_IDX_EVT_MASK: next_st.dat = {5'h00, st.evt_mask};
        default: next_st.dat = 8'h00;
      endcase
    end

    // sets come last so they win
    // period select skips every other wrap
    if (ovf1 && (!st.tb || st.half))
    begin
      next_st.first_timebase_flag = 1'b1;
      next_st.evt_stat[LTC_EVT_TB1] = 1'b1;
    end
    if (ovf2)
    begin
      next_st.second_timebase_flag = 1'b1;
      next_st.evt_stat[LTC_EVT_TB2] = 1'b1;
    end
    if (cap_now)
    begin
      next_st.capv = st.cnt1;
      next_st.capture_flag = 1'b1;
      next_st.evt_stat[LTC_EVT_CAP] = 1'b1;
    end

    // request lines from next flags so outputs stay registered
    next_st.irq.tb1 = next_st.first_timebase_flag && next_st.first_timebase_irq_enable;
    next_st.irq.tb2 = next_st.second_timebase_flag && next_st.second_timebase_irq_enable;
    next_st.irq.cap = next_st.capture_flag && next_st.capture_irq_enable;
    next_st.irq_any = |(next_st.evt_stat & next_st.evt_mask);
  end

  // ==========================================================
  // state register
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      st <= '0;
      st.pre <= LTC_RST_PRE;
      st.reload <= LTC_RST_BYTE;
      st.cnt2 <= LTC_RST_BYTE;
      st.capv <= LTC_RST_BYTE;
      st.evt_stat <= LTC_RST_EVT;
      st.evt_mask <= LTC_RST_EVT;
    end
    else
    begin
      st <= next_st;
    end
  end

  // outputs straight from the state flops
  assign wb_ack_o = st.ack;
  assign wb_dat_o = {24'h000000, st.dat};
  assign irq_lines_o = st.irq;
  assign irq_o = st.irq_any;

  // ==========================================================
  // assertions
  default clocking ltc_cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  AST_TB2_IRQ_GATE: assert property (irq_lines_o.tb2 == (st.second_timebase_flag && st.second_timebase_irq_enable))
    else $error("timebase-2 request does not follow flag and enable");

  AST_TB2_SET_RELOAD: assert property (ovf2 |=> st.second_timebase_flag && st.cnt2 == $past(st.reload))
    else $error("counter 2 overflow did not set flag and reload");

  AST_TB2_READ_CLR: assert property ((rd && idx == LTC_IDX_CSR2 && !ovf2) |=> !st.second_timebase_flag)
    else $error("timebase-2 flag survived a clearing read");

  AST_CNT2_WRITE_IGNORED: assert property ((wr && idx == LTC_IDX_CNT2 && !tick) |=>
    $stable(st.cnt2))
    else $error("write changed counter 2");

  AST_CAP_LATCH: assert property (cap_now |=>
    st.capture_flag && st.capv == $past(st.cnt1) && irq_lines_o.cap == st.capture_irq_enable)
    else $error("capture did not latch counter 1");

  AST_CAP_HOLD: assert property ((st.capture_flag && !(rd && idx == LTC_IDX_CAPTURE)) |=>
    $stable(st.capv) && st.capture_flag)
    else $error("capture value changed while flag set");

  AST_TB1_WRAP: assert property (ovf1 |=> st.cnt1 == 8'h00)
    else $error("counter 1 did not wrap to zero");

  AST_TB1_PERIOD: assert property ((ovf1 && st.tb && !st.half) |=> !$rose(st.first_timebase_flag))
    else $error("doubled period flagged on the first wrap");

  AST_HALT_STOP: assert property (halt_i |=>
    $stable(st.cnt1) && $stable(st.cnt2) && $stable(st.pre))
    else $error("counters moved in halt");

  AST_CSR1_READ: assert property ((rd && idx == LTC_IDX_CSR1) |=>
    wb_ack_o && wb_dat_o[7:0] == $past(csr1_rd))
    else $error("first control register read wrong");

  AST_ACK_DROP: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held for two cycles");

  AST_TB1_IRQ_GATE: assert property (irq_lines_o.tb1 == (st.first_timebase_flag && st.first_timebase_irq_enable))
    else $error("timebase-1 request does not follow flag and enable");

  AST_CAP_IRQ_GATE: assert property (irq_lines_o.cap == (st.capture_flag && st.capture_irq_enable))
    else $error("capture request does not follow flag and enable");

  AST_TB1_SET: assert property ((ovf1 && (!st.tb || st.half)) |=> st.first_timebase_flag)
    else $error("counter 1 wrap did not set its flag");

  AST_TB1_READ_CLR: assert property ((rd && idx == LTC_IDX_CSR1 && !ovf1) |=> !st.first_timebase_flag)
    else $error("timebase-1 flag survived a clearing read");

  AST_CAP_READ_CLR: assert property ((rd && idx == LTC_IDX_CAPTURE && !cap_now) |=>
    !st.capture_flag)
    else $error("capture flag survived a capture register read");

  AST_CAP_FLAG_WRITE: assert property ((wr && idx == LTC_IDX_CSR1 && st.capture_flag) |=> st.capture_flag)
    else $error("write cleared the capture flag");

  AST_CNT2_STEP: assert property ((tick && !ovf2) |=>
    st.cnt2 == 8'($past(st.cnt2) + 8'h01))
    else $error("counter 2 did not step by one");

  AST_RELOAD_WRITE: assert property ((wr && idx == LTC_IDX_RELOAD) |=>
    st.reload == $past(wb_dat_i[7:0]))
    else $error("reload register did not take the written byte");

  AST_CSR2_READ: assert property ((rd && idx == LTC_IDX_CSR2) |=>
    wb_ack_o && wb_dat_o[7:0] == $past(csr2_rd) && wb_dat_o[7:2] == 6'h00)
    else $error("second control register read wrong");

  AST_SET_WINS: assert property ((ovf2 && rd && idx == LTC_IDX_CSR2) |=> st.second_timebase_flag)
    else $error("overflow lost to a clearing read");

  AST_ACK_NEXT: assert property (take |=> wb_ack_o)
    else $error("request not answered in the next cycle");

  COV_CAPTURE: cover property (cap_now ##1 irq_lines_o.cap);
  COV_TB1_DOUBLE: cover property (ovf1 && st.tb && st.half);
  COV_TB2_OVF: cover property (ovf2 ##1 irq_lines_o.tb2);
  COV_SET_BEATS_CLR: cover property (ovf2 && rd && idx == LTC_IDX_CSR2);
  COV_CAP_INHIBIT: cover property (edge_seen && st.capture_flag);

endmodule : ltc_timer

//--- tb/ltc_edge_src.sv
// model of the edge source on the capture pin
`timescale 1ns/1ps

module ltc_edge_src (
  input wire logic clk_i,
  input wire logic fire_i,
  output logic pin_o
);
  logic lvl = 1'b0;
  // ==========
  // push-pull line, one toggle per request; idles low like the history flop
  always @(posedge clk_i)
  begin
    if (fire_i)
      lvl <= ~lvl;
  end
  assign pin_o = lvl;
endmodule : ltc_edge_src

//--- tb/tb_top.sv
// self-checking bench for the timebase and capture timer
`timescale 1ns/1ps

module tb_top;
  import ltc_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic we = 1'b0;
  logic halt = 1'b0;
  logic fire = 1'b0;
  logic pin;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic ack;
  logic irq;
  ltc_irq_t irql;
  logic [15:0] expq[$];
  logic [15:0] q;
  logic [7:0] rnd;
  int bad_count = 0;
  int tests_run = 0;
  longint t0;

  // ==========
  // clock and instances
  initial forever #2.5 clk_i = ~clk_i;
  ltc_timer i_ltc_timer (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .capture_input_pin_i(pin), .halt_i(halt), .irq_lines_o(irql),
    .irq_o(irq));
  ltc_edge_src i_ltc_edge_src (.clk_i(clk_i), .fire_i(fire), .pin_o(pin));

  // ==========
  // tasks
  task automatic final_report;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : final_report

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e)
    begin
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      bad_count++;
    end
  endtask : chk

  // a wait that uses up its bound counts as a mismatch and ends the run
  task automatic tmo(input int n, input int lim);
    if (n >= lim)
    begin
      bad_count++;
      final_report();
    end
  endtask : tmo

  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    @(posedge clk_i);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h0, d};
    n = 0;
    // request stands until ack is sampled high at a rising edge
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (ack !== 1'b1 && n < 50);
    tmo(n, 50);
    // release at the very edge that took the answer
    cyc <= 1'b0;
  endtask : bus

  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
    expq.push_back({m, e & m});
    bus(1'b0, a, 8'h00);
  endtask : rd

  task automatic wait_irq(input int b, input int lim);
    int n;
    n = 0;
    while (irql[b] !== 1'b1 && n < lim)
    begin
      @(negedge clk_i);
      n++;
    end
    tmo(n, lim);
  endtask : wait_irq

  // ==========
  // read monitor: oldest note against data standing with ack at the edge
  always @(posedge clk_i)
  begin
    if (ack === 1'b1 && cyc && !we && expq.size() > 0)
    begin
      q = expq.pop_front();
      chk($sformatf("reg %h", adr), {24'h0, q[7:0]}, rdat & {24'hffffff, q[15:8]});
    end
  end

  // ==========
  // main sequence
  initial
  begin
    void'($urandom(32'hc4e6));
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(8'h20, 8'h00, 8'hff);
    rd(8'h2c, 8'h00, 8'hff);
    rd(8'h30, 8'h00, 8'hff);
    rd(8'h3c, 8'h00, 8'hff);
    rnd = 8'($urandom());
    bus(1'b1, 8'h24, rnd);
    rd(8'h24, rnd, 8'hff);
    bus(1'b1, 8'h20, 8'h03);
    rd(8'h20, 8'h02, 8'hfe);
    $display("test registers done");
    // short reload: counter stays within f0..ff after overflow
    bus(1'b1, 8'h24, 8'hf0);
    wait_irq(1, 9000);
    rd(8'h20, 8'h03, 8'hff);
    rd(8'h20, 8'h02, 8'hff);
    rd(8'h28, 8'hf0, 8'hf0);
    chk("tb2 line", 32'h0, {31'h0, irql.tb2});
    @(posedge clk_i) halt <= 1'b1;
    rd(8'h20, 8'h02, 8'hff);
    bus(1'b1, 8'h28, 8'h00);
    repeat (1200) @(posedge clk_i);
    rd(8'h20, 8'h02, 8'hff);
    rd(8'h28, 8'hf0, 8'hf0);
    halt <= 1'b0;
    // reload of ff overflows every tick; reads three cycles apart meet one
    bus(1'b1, 8'h24, 8'hff);
    for (int k = 0; k < 220; k++)
    begin
      rd(8'h20, 8'h02, 8'hfe);
    end
    $display("test counter two done");
    // rise to rise spacing of the timebase-1 line
    for (int s = 0; s < 2; s++)
    begin
      bus(1'b1, 8'h2c, 8'(8'h10 | (s << 5)));
      // clear a flag left from before, so that the next rise is a fresh one
      rd(8'h2c, 8'(8'h10 | (s << 5)), 8'hf7);
      wait_irq(2, 17000);
      t0 = $time;
      rd(8'h2c, 8'(8'h18 | (s << 5)), 8'hff);
      wait_irq(2, 17000);
      chk("tb1 period", 32'(40000 * (s + 1)), 32'($time - t0));
      rd(8'h2c, 8'(8'h18 | (s << 5)), 8'hff);
    end
    $display("test timebase done");
    // capture right after a wrap sees zero; second edge inhibited
    bus(1'b1, 8'h38, 8'h04);
    bus(1'b1, 8'h2c, 8'h90);
    wait_irq(2, 9000);
    @(posedge clk_i) fire <= 1'b1;
    @(posedge clk_i) fire <= 1'b0;
    wait_irq(0, 50);
    chk("irq out", 32'h1, {31'h0, irq});
    // let counter 1 move on, so that a capture not inhibited would show
    repeat (40) @(posedge clk_i);
    @(posedge clk_i) fire <= 1'b1;
    @(posedge clk_i) fire <= 1'b0;
    repeat (4) @(posedge clk_i);
    bus(1'b1, 8'h2c, 8'h90);
    rd(8'h2c, 8'hd0, 8'hf7);
    rd(8'h30, 8'h00, 8'hff);
    rd(8'h2c, 8'h90, 8'hf7);
    rd(8'h34, 8'h04, 8'h04);
    bus(1'b1, 8'h38, 8'h00);
    chk("irq masked", 32'h0, {31'h0, irq});
    bus(1'b1, 8'h38, 8'h04);
    chk("irq unmasked", 32'h1, {31'h0, irq});
    bus(1'b1, 8'h34, 8'h07);
    chk("irq cleared", 32'h0, {31'h0, irq});
    $display("test capture done");
    final_report();
  end
endmodule : tb_top
